// ---- hdl/flh_defines.svh ----
`ifndef FLH_DEFINES_SVH
`define FLH_DEFINES_SVH

// Flash command codes
`define FLH_CMD_RD_STATUS  8'h70
`define FLH_CMD_CHIP_ERASE 8'h30
`define FLH_CMD_CONFIRM    8'hD0
`define FLH_CMD_WORD_WR    8'h40
`define FLH_CMD_WORD_WR2   8'h10
`define FLH_CMD_BUF_WR     8'hE8
`define FLH_CMD_LOCK       8'h60
`define FLH_CMD_LOCK_SET   8'h01
`define FLH_CMD_RD_ARRAY   8'hFF
`define FLH_CMD_CLR_STATUS 8'h50

// Status bit positions
`define FLH_SR_READY   7
`define FLH_SR_ERASE   5
`define FLH_SR_WRITE   4
`define FLH_SR_VPP     3
`define FLH_SR_PROTECT 1
`define FLH_XSR_AVAIL  7

// Bus cycle timing
`define FLH_CLK_NS     25
`define FLH_T_WP_NS    75
`define FLH_T_ACC_NS   100
`define FLH_WP_CYC  ((`FLH_T_WP_NS + `FLH_CLK_NS - 1) / `FLH_CLK_NS)
`define FLH_ACC_CYC ((`FLH_T_ACC_NS + `FLH_CLK_NS - 1) / `FLH_CLK_NS)
`define FLH_WR_END  4'(`FLH_WP_CYC + 1)
`define FLH_RD_END  4'(`FLH_ACC_CYC + 4)

// Register word indices
`define FLH_REG_CTRL   5'h00
`define FLH_REG_CMD    5'h01
`define FLH_REG_ADDR   5'h02
`define FLH_REG_WDATA  5'h03
`define FLH_REG_COUNT  5'h04
`define FLH_REG_STAT   5'h05
`define FLH_REG_ERR    5'h06
`define FLH_REG_RDATA  5'h07
`define FLH_BUF_SEL    1'b1

// Control fields, reset value and sizes
`define FLH_CTRL_AUTOCLR 0
`define FLH_CTRL_RETARR  1
`define FLH_CTRL_WP      2
`define FLH_CTRL_RST     3'h6
`define FLH_BUF_DEPTH    16
`define FLH_ADDR_W       22
`define FLH_DQ_W         16

`endif

// ---- hdl/flh_pkg.sv ----
package flh_pkg;

    typedef enum logic [3:0] {
        FLH_OP_NONE,
        FLH_OP_STATUS,
        FLH_OP_CHIP_ERASE,
        FLH_OP_WORD,
        FLH_OP_BUF,
        FLH_OP_LOCK_SET,
        FLH_OP_LOCK_CLR,
        FLH_OP_CLR_STATUS,
        FLH_OP_READ_ARRAY
    } flh_op_e;

    typedef struct packed {
        logic        wr;
        logic [21:0] addr;
        logic [15:0] data;
    } flh_cyc_s;

    typedef struct packed {
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic [21:0] addr;
        logic [15:0] dq;
        logic        dq_oe;
    } flh_pins_s;

endpackage : flh_pkg

// ---- hdl/flh_bus_cycle.sv ----
`timescale 1ns/1ps
`include "flh_defines.svh"
module flh_bus_cycle (
    // Clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    // Cycle request
    input  wire logic              i_start,
    input  wire flh_pkg::flh_cyc_s i_cyc,
    output logic                   o_done,
    output logic [15:0]            o_rdata,
    // Flash pins
    input  wire logic [15:0]       i_fl_dq,
    output flh_pkg::flh_pins_s     o_pins
);
    import flh_pkg::*;

    logic [15:0] dq_s1_ff;
    logic [15:0] dq_s2_ff;
    logic        act_ff;
    logic [3:0]  cnt_ff;
    flh_cyc_s    cyc_ff;
    logic [15:0] rdata_ff;

    wire [3:0] end_cnt = cyc_ff.wr ? `FLH_WR_END : `FLH_RD_END;
    wire       last    = act_ff && (cnt_ff == end_cnt);
    wire       strobe  = act_ff && (cnt_ff != 4'h0) && (cnt_ff < end_cnt);
    wire       sample  = act_ff && !cyc_ff.wr && (cnt_ff == end_cnt - 4'h1);

    // Pin data is async to i_mclk
    always_ff @(posedge i_mclk) begin
        dq_s1_ff <= i_fl_dq;
        dq_s2_ff <= dq_s1_ff;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            act_ff <= 1'b0;
            cnt_ff <= 4'h0;
            cyc_ff <= '0;
        end else if (i_start && !act_ff) begin
            act_ff <= 1'b1;
            cnt_ff <= 4'h0;
            cyc_ff <= i_cyc;
        end else if (last) begin
            act_ff <= 1'b0;
        end else if (act_ff) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // Synced data lags the pins by two cycles; access time covers it
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_ff <= 16'h0000;
        end else if (sample) begin
            rdata_ff <= dq_s2_ff;
        end
    end

    assign o_done       = last;
    assign o_rdata      = rdata_ff;
    assign o_pins  = {!act_ff, !(strobe && cyc_ff.wr),
                      !(strobe && !cyc_ff.wr), cyc_ff.addr, cyc_ff.data,
                      act_ff && cyc_ff.wr};

endmodule : flh_bus_cycle

// ---- hdl/flh_host.sv ----
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "flh_defines.svh"
module flh_host (
    // Clock and reset
    input  wire logic          i_mclk,
    input  wire logic          i_rst,
    // Avalon-MM slave
    input  wire logic [4:0]    i_avs_address,
    input  wire logic          i_avs_read,
    input  wire logic          i_avs_write,
    input  wire logic [31:0]   i_avs_writedata,
    output logic [31:0]        o_avs_readdata,
    output logic               o_avs_waitrequest,
    // Flash pins
    input  wire logic [15:0]   i_fl_dq,
    output flh_pkg::flh_pins_s o_fl_pins,
    output logic               o_fl_wp_n,
    // Status
    output logic               o_busy
);
    import flh_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE,
        S_RS_CMD,
        S_RS_RD,
        S_SETUP,
        S_XS_RD,
        S_COUNT,
        S_DATA,
        S_CONFIRM,
        S_POLL,
        S_CHECK,
        S_CLR,
        S_ARRAY,
        S_AR_RD
    } flh_state_e;

    flh_state_e  state_ff;
    flh_state_e  nxt_state;
    flh_op_e     op_ff;
    logic [2:0]  ctrl_ff;
    logic [21:0] addr_ff;
    logic [15:0] wdata_ff;
    logic [3:0]  count_ff;
    logic [3:0]  idx_ff;
    logic [7:0]  status_ff;
    logic [4:0]  err_ff;
    logic [15:0] rdata_ff;
    logic        pend_ff;
    logic        rack_ff;
    logic [31:0] rd_ff;
    logic [15:0] buf_mem [`FLH_BUF_DEPTH];

    logic        cyc_done;
    logic [15:0] cyc_rdata;
    flh_cyc_s    cyc;
    logic [7:0]  setup_code;
    logic [15:0] conf_data;
    logic [4:0]  err_set;
    logic [31:0] rd_mux;

    // Register decode
    wire sel_buf  = i_avs_address[4] == `FLH_BUF_SEL;
    wire wr_ctrl  = i_avs_write && i_avs_address == `FLH_REG_CTRL;
    wire wr_cmd   = i_avs_write && i_avs_address == `FLH_REG_CMD;
    wire wr_addr  = i_avs_write && i_avs_address == `FLH_REG_ADDR;
    wire wr_wdata = i_avs_write && i_avs_address == `FLH_REG_WDATA;
    wire wr_count = i_avs_write && i_avs_address == `FLH_REG_COUNT;
    wire wr_err   = i_avs_write && i_avs_address == `FLH_REG_ERR;
    wire wr_buf   = i_avs_write && sel_buf;
    wire idle     = state_ff == S_IDLE;
    wire go       = wr_cmd && idle;

    // Status fields, valid once ready
    wire st_ready = cyc_rdata[`FLH_SR_READY];
    wire sr_ers   = status_ff[`FLH_SR_ERASE];
    wire sr_wr    = status_ff[`FLH_SR_WRITE];
    wire seq_err  = sr_ers && sr_wr;
    wire erase_op = op_ff == FLH_OP_CHIP_ERASE
                    || op_ff == FLH_OP_LOCK_CLR;
    wire write_op = op_ff == FLH_OP_WORD || op_ff == FLH_OP_BUF
                    || op_ff == FLH_OP_LOCK_SET;
    wire any_addr = erase_op;
    wire auto_clr = ctrl_ff[`FLH_CTRL_AUTOCLR];
    wire ret_arr  = ctrl_ff[`FLH_CTRL_RETARR];

    assign err_set[0] = status_ff[`FLH_SR_VPP];
    assign err_set[1] = status_ff[`FLH_SR_PROTECT];
    assign err_set[2] = seq_err;
    assign err_set[3] = erase_op && sr_ers && !sr_wr;
    assign err_set[4] = write_op && sr_wr && !sr_ers;

    // Setup and confirm codes
    always_comb begin
        case (op_ff)
            FLH_OP_CHIP_ERASE: setup_code = `FLH_CMD_CHIP_ERASE;
            FLH_OP_WORD:       setup_code = `FLH_CMD_WORD_WR;
            FLH_OP_BUF:        setup_code = `FLH_CMD_BUF_WR;
            FLH_OP_LOCK_SET:   setup_code = `FLH_CMD_LOCK;
            FLH_OP_LOCK_CLR:   setup_code = `FLH_CMD_LOCK;
            default:           setup_code = `FLH_CMD_RD_STATUS;
        endcase
    end

    always_comb begin
        case (op_ff)
            FLH_OP_WORD:     conf_data = wdata_ff;
            FLH_OP_LOCK_SET: conf_data = {8'h00, `FLH_CMD_LOCK_SET};
            default:         conf_data = {8'h00, `FLH_CMD_CONFIRM};
        endcase
    end

    // Bus cycle per state
    always_comb begin
        cyc.wr   = 1'b1;
        cyc.addr = any_addr ? 22'h000000 : addr_ff;
        cyc.data = 16'h0000;
        case (state_ff)
            S_RS_CMD:  cyc.data = {8'h00, `FLH_CMD_RD_STATUS};
            S_SETUP:   cyc.data = {8'h00, setup_code};
            S_COUNT:   cyc.data = {12'h000, count_ff};
            S_DATA: begin
                cyc.addr = addr_ff + {18'h00000, idx_ff};
                cyc.data = buf_mem[idx_ff];
            end
            S_CONFIRM: cyc.data = conf_data;
            S_CLR:     cyc.data = {8'h00, `FLH_CMD_CLR_STATUS};
            S_ARRAY:   cyc.data = {8'h00, `FLH_CMD_RD_ARRAY};
            default:   cyc.wr = 1'b0;
        endcase
    end

    wire cyc_act = !(idle || state_ff == S_CHECK);
    wire cyc_go  = cyc_act && !pend_ff;
    wire after_clr_arr = ret_arr && op_ff != FLH_OP_CLR_STATUS;

    // Operation sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (go) begin
                    case (flh_op_e'(i_avs_writedata[3:0]))
                        FLH_OP_NONE:        nxt_state = S_IDLE;
                        FLH_OP_READ_ARRAY:  nxt_state = S_ARRAY;
                        FLH_OP_CLR_STATUS:  nxt_state = S_CLR;
                        default:            nxt_state = S_RS_CMD;
                    endcase
                end
            end
            S_RS_CMD:  if (cyc_done) nxt_state = S_RS_RD;
            S_RS_RD: begin
                if (cyc_done && st_ready) begin
                    nxt_state = op_ff == FLH_OP_STATUS ? S_CHECK
                                                       : S_SETUP;
                end
            end
            S_SETUP: begin
                if (cyc_done) begin
                    nxt_state = op_ff == FLH_OP_BUF ? S_XS_RD
                                                    : S_CONFIRM;
                end
            end
            S_XS_RD: begin
                if (cyc_done && cyc_rdata[`FLH_XSR_AVAIL]) begin
                    nxt_state = S_COUNT;
                end
            end
            S_COUNT:   if (cyc_done) nxt_state = S_DATA;
            S_DATA: begin
                if (cyc_done && idx_ff == count_ff) begin
                    nxt_state = S_CONFIRM;
                end
            end
            S_CONFIRM: if (cyc_done) nxt_state = S_POLL;
            S_POLL: begin
                if (cyc_done && st_ready) nxt_state = S_CHECK;
            end
            S_CHECK: begin
                if (seq_err && auto_clr) begin
                    nxt_state = S_CLR;
                end else if (ret_arr) begin
                    nxt_state = S_ARRAY;
                end else begin
                    nxt_state = S_IDLE;
                end
            end
            S_CLR: begin
                if (cyc_done) begin
                    nxt_state = after_clr_arr ? S_ARRAY : S_IDLE;
                end
            end
            S_ARRAY: begin
                if (cyc_done) begin
                    nxt_state = op_ff == FLH_OP_READ_ARRAY ? S_AR_RD
                                                           : S_IDLE;
                end
            end
            S_AR_RD:   if (cyc_done) nxt_state = S_IDLE;
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_ff <= S_IDLE;
            pend_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pend_ff  <= cyc_done ? 1'b0 : (pend_ff || cyc_go);
        end
    end

    // Operation and buffer index
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            op_ff  <= FLH_OP_NONE;
            idx_ff <= 4'h0;
        end else begin
            if (go) op_ff <= flh_op_e'(i_avs_writedata[3:0]);
            if (state_ff == S_COUNT) idx_ff <= 4'h0;
            else if (state_ff == S_DATA && cyc_done) idx_ff <= idx_ff + 4'h1;
        end
    end

    // Status is latched only once ready reads 1
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            status_ff <= 8'h80;
        end else if (cyc_done && st_ready
                     && (state_ff == S_RS_RD || state_ff == S_POLL)) begin
            status_ff <= cyc_rdata[7:0];
        end
    end

    // Errors accumulate across deferred checks; set beats clear
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            err_ff <= 5'h00;
        end else begin
            err_ff <= (err_ff & ~(wr_err ? i_avs_writedata[4:0] : 5'h00))
                      | (state_ff == S_CHECK ? err_set : 5'h00);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_ff <= 16'h0000;
        end else if (state_ff == S_AR_RD && cyc_done) begin
            rdata_ff <= cyc_rdata;
        end
    end

    // Software registers; writes while busy are ignored, except error clears, which still apply
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_ff  <= `FLH_CTRL_RST;
            addr_ff  <= 22'h000000;
            wdata_ff <= 16'h0000;
            count_ff <= 4'h0;
        end else if (idle) begin
            if (wr_ctrl)  ctrl_ff  <= i_avs_writedata[2:0];
            if (wr_addr)  addr_ff  <= i_avs_writedata[21:0];
            if (wr_wdata) wdata_ff <= i_avs_writedata[15:0];
            if (wr_count) count_ff <= i_avs_writedata[3:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (wr_buf && idle) begin
            buf_mem[i_avs_address[3:0]] <= i_avs_writedata[15:0];
        end
    end

    // Read mux
    always_comb begin
        case (i_avs_address)
            `FLH_REG_CTRL:  rd_mux = {29'h0, ctrl_ff};
            `FLH_REG_CMD:   rd_mux = {28'h0, op_ff};
            `FLH_REG_ADDR:  rd_mux = {10'h0, addr_ff};
            `FLH_REG_WDATA: rd_mux = {16'h0, wdata_ff};
            `FLH_REG_COUNT: rd_mux = {28'h0, count_ff};
            `FLH_REG_STAT:  rd_mux = {23'h0, !idle, status_ff};
            `FLH_REG_ERR:   rd_mux = {27'h0, err_ff};
            `FLH_REG_RDATA: rd_mux = {16'h0, rdata_ff};
            default:        rd_mux = sel_buf
                ? {16'h0, buf_mem[i_avs_address[3:0]]} : 32'h0;
        endcase
    end

    // One wait state on reads keeps readdata registered
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rack_ff <= 1'b0;
            rd_ff   <= 32'h0;
        end else begin
            rack_ff <= i_avs_read && !rack_ff;
            rd_ff   <= rd_mux;
        end
    end

    assign o_avs_waitrequest = i_avs_read && !rack_ff;
    assign o_avs_readdata    = rd_ff;
    assign o_fl_wp_n         = ctrl_ff[`FLH_CTRL_WP];
    assign o_busy            = !idle;

    flh_bus_cycle u_cycle (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_start (cyc_go),
        .i_cyc   (cyc),
        .o_done  (cyc_done),
        .o_rdata (cyc_rdata),
        .i_fl_dq (i_fl_dq),
        .o_pins  (o_fl_pins)
    );

endmodule : flh_host

// ---- tb/flh_host_chk.sv ----
`timescale 1ns/1ps
module flh_host_chk (
    // Clock and reset
    input wire logic               i_mclk,
    input wire logic               i_rst,
    // Avalon-MM slave
    input wire logic [4:0]         i_avs_address,
    input wire logic               i_avs_read,
    input wire logic               i_avs_write,
    input wire logic [31:0]        i_avs_writedata,
    input wire logic [31:0]        o_avs_readdata,
    input wire logic               o_avs_waitrequest,
    // Flash side and status
    input wire logic [15:0]        i_fl_dq,
    input wire flh_pkg::flh_pins_s o_fl_pins,
    input wire logic               o_fl_wp_n,
    input wire logic               o_busy
);
    import flh_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    logic [7:0]  pd_ff;
    logic [21:0] pa_ff;
    logic        first_ff;

    // Last command write of this sequence
    always_ff @(posedge i_mclk) begin
        if (i_rst || !o_busy) begin
            pd_ff    <= 8'h00;
            pa_ff    <= 22'h0;
            first_ff <= 1'b1;
        end else if ($fell(o_fl_pins.we_n)) begin
            pd_ff    <= o_fl_pins.dq[7:0];
            pa_ff    <= o_fl_pins.addr;
            first_ff <= 1'b0;
        end
    end

    sequence s_wr_start;
        $fell(o_fl_pins.we_n);
    endsequence
    sequence s_wr_hold;
        (!o_fl_pins.ce_n && o_fl_pins.dq_oe && $stable(o_fl_pins.addr)
            && $stable(o_fl_pins.dq))[*3] ##1 o_fl_pins.we_n;
    endsequence

    property p_wr_pulse;
        s_wr_start |-> s_wr_hold;
    endproperty
    property p_first_cmd;
        s_wr_start and first_ff
            |-> o_fl_pins.dq[7:0] inside {8'h70, 8'h50, 8'hFF};
    endproperty
    property p_erase_pair;
        s_wr_start and pd_ff == 8'h30 |-> o_fl_pins.dq[7:0] == 8'hD0;
    endproperty
    property p_word_pair;
        s_wr_start and (pd_ff == 8'h40 || pd_ff == 8'h10)
            |-> o_fl_pins.addr == pa_ff;
    endproperty
    property p_buf_count;
        s_wr_start and pd_ff == 8'hE8 |-> o_fl_pins.addr == pa_ff;
    endproperty
    property p_lock_pair;
        s_wr_start and pd_ff == 8'h60 |-> o_fl_pins.dq[7:0] == 8'hD0
            || (o_fl_pins.dq[7:0] == 8'h01 && o_fl_pins.addr == pa_ff);
    endproperty
    property p_rd_safe;
        !o_fl_pins.oe_n |-> o_fl_pins.we_n && !o_fl_pins.dq_oe;
    endproperty
    property p_rd_answer;
        i_avs_read && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    property p_wp_hold;
        o_busy && $past(o_busy) |-> $stable(o_fl_wp_n);
    endproperty

    a_wr_pulse: assert property (p_wr_pulse)
        else $error("bad write strobe");
    a_first_cmd: assert property (p_first_cmd)
        else $error("bad first command");
    a_erase_pair: assert property (p_erase_pair)
        else $error("erase pair broken");
    a_word_pair: assert property (p_word_pair)
        else $error("word data address");
    a_buf_count: assert property (p_buf_count)
        else $error("count address");
    a_lock_pair: assert property (p_lock_pair)
        else $error("bad lock confirm");
    a_rd_safe: assert property (p_rd_safe)
        else $error("bus clash on read");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    a_wp_hold: assert property (p_wp_hold)
        else $error("protect pin moved");
endmodule : flh_host_chk

bind flh_host flh_host_chk u_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_fl_dq(i_fl_dq),
    .o_fl_pins(o_fl_pins), .o_fl_wp_n(o_fl_wp_n), .o_busy(o_busy)
);

// ---- tb/flh_dev_model.sv ----
`timescale 1ns/1ps
module flh_dev_model #(
    parameter int BLK_SH = 16
) (
    // Clock and host pins
    input  wire logic               i_mclk,
    input  wire flh_pkg::flh_pins_s i_pins,
    input  wire logic               i_wp_n,
    // Pace and fault controls
    input  wire logic               i_slow,
    input  wire logic [1:0]         i_fault,
    output logic [15:0]             o_dq
);
    import flh_pkg::*;
    logic [7:0]  sr_ff = 8'h00, pend_ff = 8'h00;
    logic [1:0]  mode_ff = 2'd0;
    logic        we_q_ff = 1'b1, bad_ff = 1'b0;
    logic [21:0] la_ff = 22'h0, base_ff = 22'h0;
    logic [15:0] ld_ff = 16'h0, last_ff = 16'h0, val;
    int          busy_ff = 0, left_ff = -1;
    logic [15:0] mem [int];
    bit          lock [int];
    logic [21:0] qa [$];
    logic [15:0] qd [$];
    wire         drv = !i_pins.ce_n && !i_pins.oe_n;

    task automatic go(input int k, input bit prot, output bit ok);
        busy_ff = i_slow ? 40 : 3;
        mode_ff = 2'd1;
        ok = 1'b0;
        if (prot)
            sr_ff = sr_ff | 8'h02 | (8'h01 << k);
        else if (i_fault[1])
            sr_ff = sr_ff | 8'h08 | (8'h01 << k);
        else if (i_fault[0])
            sr_ff = sr_ff | (8'h01 << k);
        else
            ok = 1'b1;
    endtask : go

    task automatic seq_err();
        sr_ff = sr_ff | 8'h30;
        mode_ff = 2'd1;
        pend_ff = 8'h00;
        qa.delete();
        qd.delete();
    endtask : seq_err

    task automatic cmd(input logic [21:0] a, input logic [15:0] d);
        bit ok;
        logic [7:0] c;
        c = d[7:0];
        if (pend_ff == 8'h40) begin
            pend_ff = 8'h00;
            go(4, lock[a >> BLK_SH] && !i_wp_n, ok);
            if (ok)
                mem[a] = d;
        end else if (pend_ff == 8'hE8) begin
            if (left_ff < 0) begin
                left_ff = int'(c) + 1;
            end else if (left_ff > 0) begin
                bad_ff = bad_ff | ((a >> BLK_SH) != (base_ff >> BLK_SH));
                qa.push_back(a);
                qd.push_back(d);
                left_ff = left_ff - 1;
            end else if (c == 8'hD0 && !bad_ff) begin
                pend_ff = 8'h00;
                go(4, lock[base_ff >> BLK_SH] && !i_wp_n, ok);
                while (ok && qa.size() > 0)
                    mem[qa.pop_front()] = qd.pop_front();
            end else
                seq_err();
        end else if (pend_ff == 8'h30) begin
            pend_ff = 8'h00;
            if (c != 8'hD0)
                seq_err();
            else begin
                go(5, 1'b0, ok);
                if (ok)
                    mem.delete();
            end
        end else if (pend_ff == 8'h60) begin
            pend_ff = 8'h00;
            if (c == 8'h01) begin
                go(4, !i_wp_n, ok);
                if (ok)
                    lock[a >> BLK_SH] = 1'b1;
            end else if (c == 8'hD0) begin
                go(5, !i_wp_n, ok);
                if (ok)
                    lock.delete();
            end else
                seq_err();
        end else
            case (c)
                8'h70: mode_ff = 2'd1;
                8'h50: sr_ff = 8'h00;
                8'hFF: mode_ff = 2'd0;
                8'h40, 8'h10: pend_ff = 8'h40;
                8'h30, 8'h60: pend_ff = c;
                8'hE8: begin
                    pend_ff = c;
                    mode_ff = 2'd2;
                    left_ff = -1;
                    bad_ff = 1'b0;
                    base_ff = a;
                end
                default: ;
            endcase
    endtask : cmd

    // Sample mid-cycle, clear of host edges
    always @(negedge i_mclk) begin
        if (drv)
            last_ff = val;
        if (busy_ff > 0)
            busy_ff = busy_ff - 1;
        if (!i_pins.ce_n && !i_pins.we_n) begin
            la_ff = i_pins.addr;
            ld_ff = i_pins.dq;
        end
        if (!we_q_ff && i_pins.we_n && busy_ff == 0)
            cmd(la_ff, ld_ff);
        we_q_ff = i_pins.we_n;
    end

    always @* begin
        if (mode_ff == 2'd0)
            val = mem.exists(i_pins.addr) ? mem[i_pins.addr] : 16'hFFFF;
        else if (mode_ff == 2'd2)
            val = 16'h0080;
        else if (busy_ff > 0)
            val = 16'h007E;
        else
            val = {8'h00, 1'b1, sr_ff[6:0]};
    end
    // Released bus shows no stale data
    assign o_dq = drv ? val : ~last_ff;
endmodule : flh_dev_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import flh_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic        slow = 1'b0, wait_rq, wp_n, busy;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [15:0] dev_dq, dq_w;
    flh_pins_s   pins;
    logic [1:0]  fault = 2'b00;
    int          mismatches = 0, compares = 0;

    assign dq_w = pins.dq_oe ? pins.dq : dev_dq;

    flh_host DUT (
        .i_mclk(clk), .i_rst(rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wait_rq),
        .i_fl_dq(dq_w), .o_fl_pins(pins), .o_fl_wp_n(wp_n), .o_busy(busy)
    );
    flh_dev_model u_dev (
        .i_mclk(clk), .i_pins(pins), .i_wp_n(wp_n), .i_slow(slow),
        .i_fault(fault), .o_dq(dev_dq)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic summarize();
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic r, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        adr <= a;
        wdat <= d;
        rd <= r;
        wr <= !r;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_rq !== 1'b0 && n < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wait_rq !== 1'b0) begin
            mismatches++;
            summarize();
        end
        @(posedge clk);
    endtask : bus

    task automatic w(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask : w

    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b1, a, 32'h0, q);
        chk(q, e);
    endtask : rchk

    // Host polls are unbounded; bound here
    task automatic op(input flh_op_e c);
        int n;
        w(5'h01, {28'h0, c});
        n = 0;
        while (busy !== 1'b1 && n < 4) begin
            @(posedge clk);
            n++;
        end
        while (busy !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            mismatches++;
            summarize();
        end
    endtask : op

    task automatic t_reset();
        rchk(5'h00, 32'h6);
        rchk(5'h06, 32'h0);
        rchk(5'h08, 32'h0);
        chk({31'h0, wp_n}, 32'h1);
    endtask : t_reset

    task automatic t_word();
        w(5'h02, 32'h123);
        w(5'h03, 32'hA55A);
        op(FLH_OP_WORD);
        chk(u_dev.mem[22'h123], 32'hA55A);
        chk(u_dev.mode_ff, 32'h0);
        rchk(5'h05, 32'h80);
        op(FLH_OP_READ_ARRAY);
        rchk(5'h07, 32'hA55A);
    endtask : t_word

    task automatic t_buf();
        for (int i = 0; i < 16; i++)
            w(5'(16 + i), 32'h1200 + i);
        w(5'h02, 32'h200);
        w(5'h04, 32'hF);
        op(FLH_OP_BUF);
        for (int i = 0; i < 16; i++)
            chk(u_dev.mem[22'h200 + i], 32'h1200 + i);
        rchk(5'h06, 32'h0);
    endtask : t_buf

    task automatic t_cross();
        w(5'h00, 32'h7);
        w(5'h02, 32'hFFFE);
        w(5'h04, 32'h3);
        op(FLH_OP_BUF);
        rchk(5'h06, 32'h4);
        chk(u_dev.mem.exists(22'h10000), 32'h0);
        op(FLH_OP_STATUS);
        rchk(5'h05, 32'h80);
        w(5'h06, 32'h1F);
        rchk(5'h06, 32'h0);
    endtask : t_cross

    task automatic t_fault();
        flh_op_e     ops [6] = '{FLH_OP_CHIP_ERASE, FLH_OP_WORD, FLH_OP_BUF,
                                 FLH_OP_LOCK_SET, FLH_OP_LOCK_CLR,
                                 FLH_OP_WORD};
        logic [1:0]  f [6] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2};
        logic [31:0] e [6] = '{32'h8, 32'h10, 32'h10, 32'h10, 32'h8, 32'h11};
        logic [31:0] s [6] = '{32'hA0, 32'h90, 32'h90, 32'h90, 32'hA0, 32'h98};
        slow <= 1'b1;
        w(5'h02, 32'h300);
        for (int i = 0; i < 6; i++) begin
            fault <= f[i];
            op(ops[i]);
            fault <= 2'b00;
            rchk(5'h06, e[i]);
            op(FLH_OP_STATUS);
            rchk(5'h05, s[i]);
            op(FLH_OP_CLR_STATUS);
            op(FLH_OP_STATUS);
            rchk(5'h05, 32'h80);
            w(5'h06, 32'h1F);
        end
        slow <= 1'b0;
    endtask : t_fault

    task automatic t_lock();
        w(5'h02, 32'h10000);
        op(FLH_OP_LOCK_SET);
        chk(u_dev.lock.exists(1), 32'h1);
        w(5'h00, 32'h3);
        w(5'h02, 32'h10004);
        w(5'h03, 32'hBEEF);
        op(FLH_OP_WORD);
        rchk(5'h06, 32'h12);
        chk(u_dev.mem.exists(22'h10004), 32'h0);
        w(5'h06, 32'h1F);
        op(FLH_OP_CLR_STATUS);
        w(5'h00, 32'h7);
        op(FLH_OP_LOCK_CLR);
        chk(u_dev.lock.size(), 32'h0);
        op(FLH_OP_WORD);
        chk(u_dev.mem[22'h10004], 32'hBEEF);
        op(FLH_OP_CHIP_ERASE);
        chk(u_dev.mem.size(), 32'h0);
        rchk(5'h06, 32'h0);
    endtask : t_lock

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_word();
        t_buf();
        t_cross();
        t_fault();
        t_lock();
        summarize();
    end
endmodule : tb_top
